// ---- common/gcr_regs.vh ----
// Register map constants for the graphics core register window.
// Assumes a dword-wide target port fed by the host bus interface.
`ifndef GCR_REGS_VH
`define GCR_REGS_VH

// Placement of the register space inside the device window
`define GCR_CORE_OFF      32'h0000_0000
`define GCR_REG_OFF       32'h0010_0000
`define GCR_SPACE_BITS    20
`define GCR_RESET_VAL     32'h0000_0000

// Byte offsets within the 512-byte core
`define GCR_OFF_COPY_BUF0 9'h000
`define GCR_OFF_COPY_BUF7 9'h01c
`define GCR_OFF_FG        9'h020
`define GCR_OFF_BG        9'h024
`define GCR_OFF_PLANE     9'h028
`define GCR_OFF_PXM_ONE   9'h02c
`define GCR_OFF_MODE      9'h030
`define GCR_OFF_ADDR      9'h03c
`define GCR_OFF_CONT      9'h04c
`define GCR_OFF_DEPTH     9'h050
`define GCR_OFF_RSV_054   9'h054
`define GCR_OFF_STENCIL   9'h058
`define GCR_OFF_PXM_PERS  9'h05c
`define GCR_OFF_CUR_BASE  9'h060
`define GCR_OFF_VERT      9'h068
`define GCR_OFF_VID_BASE  9'h06c
`define GCR_OFF_VALID     9'h070
`define GCR_OFF_VSHIFT    9'h078
`define GCR_OFF_XFER_BASE 9'h098
`define GCR_OFF_ZBASE     9'h0a8
`define GCR_OFF_ADDR_ALI  9'h0ac
`define GCR_OFF_RED_VAL   9'h0b0
`define GCR_OFF_BLUE_VAL  9'h0b8
`define GCR_OFF_SPAN      9'h0bc
`define GCR_OFF_PAL_SETUP 9'h0c0
`define GCR_OFF_SLOPE_N0  9'h100
`define GCR_OFF_FILL0     9'h140
`define GCR_OFF_FILL7     9'h15c
`define GCR_OFF_COPY_SRC  9'h160
`define GCR_OFF_COPY_DST  9'h164
`define GCR_OFF_COPY_LAST 9'h17c
`define GCR_OFF_NV_WRITE  9'h1e0
`define GCR_OFF_CLK_GEN   9'h1e8
`define GCR_OFF_PAL_DATA  9'h1f0
`define GCR_OFF_CMD_STATE 9'h1f8

// Offsets named one by one in the access tables
`define GCR_OFF_COPY_BUF1 9'h004
`define GCR_OFF_COPY_BUF2 9'h008
`define GCR_OFF_COPY_BUF3 9'h00c
`define GCR_OFF_COPY_BUF4 9'h010
`define GCR_OFF_COPY_BUF5 9'h014
`define GCR_OFF_COPY_BUF6 9'h018
`define GCR_OFF_RASTER    9'h034
`define GCR_OFF_PSHIFT    9'h038
`define GCR_OFF_STEP1     9'h040
`define GCR_OFF_STEP2     9'h044
`define GCR_OFF_STEP3     9'h048
`define GCR_OFF_HORZ      9'h064
`define GCR_OFF_CUR_POS   9'h074
`define GCR_OFF_INT_STATE 9'h07c
`define GCR_OFF_DATA      9'h080
`define GCR_OFF_RED_STEP  9'h084
`define GCR_OFF_GRN_STEP  9'h088
`define GCR_OFF_BLU_STEP  9'h08c
`define GCR_OFF_ZSTEP_LO  9'h090
`define GCR_OFF_ZSTEP_HI  9'h094
`define GCR_OFF_LINE_WID  9'h09c
`define GCR_OFF_ZVAL_LO   9'h0a0
`define GCR_OFF_ZVAL_HI   9'h0a4
`define GCR_OFF_GRN_VAL   9'h0b4
`define GCR_OFF_FILL1     9'h144
`define GCR_OFF_FILL2     9'h148
`define GCR_OFF_FILL3     9'h14c
`define GCR_OFF_FILL4     9'h150
`define GCR_OFF_FILL5     9'h154
`define GCR_OFF_FILL6     9'h158
`define GCR_OFF_SRC_ALI1  9'h168
`define GCR_OFF_DST_ALI1  9'h16c
`define GCR_OFF_SRC_ALI2  9'h170
`define GCR_OFF_DST_ALI2  9'h174
`define GCR_OFF_SRC_ALI3  9'h178

// Field positions
`define GCR_BUSY_BIT      0

`endif

// ---- verilog/gcr_register_map.v ----
// Core register window of the graphics accelerator: decode and storage.
// Assumes the host bus target has already qualified a memory cycle and
// presents one dword access at a time on req_i, synchronous to clock_i.
//
// What this block does
// RULE1 - Offsets are taken relative to base address plus core and register space offsets.
// RULE2 - The copy source register at 160 also takes writes at 168, 170 and 178.
// RULE3 - The copy destination register at 164 also takes writes at 16C, 174 and 17C.
// RULE4 - Eight write-only fill colour registers sit at 140 through 15C.
// RULE5 - Eight readable and writable copy buffer words sit at 000 through 01C.
// RULE6 - The pixel mask is one-shot read/write at 02C and persistent write-only at 05C.
// RULE7 - Some registers, such as command state, may read back other than what was written.
// RULE8 - The palette setup register is write-only at 0C0.
// RULE9 - The palette data register is read/write at 1F0.
// RULE10 - The transfer base register is read/write at 098.
// RULE11 - The video shift address register is read/write at 078.
// RULE12 - The cursor base register is read/write at 060.
// RULE13 - The 512-byte core repeats across the whole 1MB register space.
// RULE14 - Accesses are whole dwords and byte enables are ignored.
// RULE15 - Reserved writes are dropped; reserved and write-only reads return zero.
// RULE16 - A write at the address alias acts exactly as one at the primary address register.

`include "gcr_regs.vh"

module gcr_register_map (
    input  wire        clock_i,
    input  wire        rst_i,
    input  wire        req_i,
    input  wire        wr_i,
    input  wire [31:0] addr_i,
    input  wire [31:0] wdata_i,
    input  wire [3:0]  be_i,
    input  wire [31:0] pci_base_i,
    input  wire        busy_i,
    output reg         ack_o,
    output reg  [31:0] rdata_o,
    output reg         wr_pulse_o,
    output reg  [6:0]  wr_index_o,
    output reg  [31:0] wr_data_o,
    output wire [31:0] drawing_mode_o,
    output wire [31:0] draw_address_o
);

    // Offsets picked out by name; bits 8:2 give the storage slot
    localparam [8:0] OFF_MODE     = `GCR_OFF_MODE;
    localparam [8:0] OFF_ADDR     = `GCR_OFF_ADDR;
    localparam [8:0] OFF_COPY_SRC = `GCR_OFF_COPY_SRC;
    localparam [8:0] OFF_COPY_DST = `GCR_OFF_COPY_DST;

    // Relative offset into the register space
    wire [31:0] rel_addr;
    wire        space_hit;
    wire [8:0]  core_off;

    assign rel_addr  = addr_i - pci_base_i - `GCR_CORE_OFF - `GCR_REG_OFF; // RULE1
    assign space_hit = (rel_addr[31:`GCR_SPACE_BITS] == 12'h000);
    // Only the low nine bits select a register, so every 512-byte slot aliases
    assign core_off  = {rel_addr[8:2], 2'b00}; // RULE13

    // Byte enables are not part of the decode at all
    wire [3:0] be_unused;
    assign be_unused = be_i; // RULE14

    // Readable locations, one by one so no range can swallow a gap
    function readable;
        input [8:0] off;
        begin
            case (off)
                `GCR_OFF_COPY_BUF0: begin
                    readable = 1'b1; // RULE5
                end
                `GCR_OFF_COPY_BUF1: begin
                    readable = 1'b1; // RULE5
                end
                `GCR_OFF_COPY_BUF2: begin
                    readable = 1'b1; // RULE5
                end
                `GCR_OFF_COPY_BUF3: begin
                    readable = 1'b1; // RULE5
                end
                `GCR_OFF_COPY_BUF4: begin
                    readable = 1'b1; // RULE5
                end
                `GCR_OFF_COPY_BUF5: begin
                    readable = 1'b1; // RULE5
                end
                `GCR_OFF_COPY_BUF6: begin
                    readable = 1'b1; // RULE5
                end
                `GCR_OFF_COPY_BUF7: begin
                    readable = 1'b1; // RULE5
                end
                `GCR_OFF_FG: begin
                    readable = 1'b1;
                end
                `GCR_OFF_BG: begin
                    readable = 1'b1;
                end
                `GCR_OFF_PXM_ONE: begin
                    readable = 1'b1; // RULE6
                end
                `GCR_OFF_MODE: begin
                    readable = 1'b1;
                end
                `GCR_OFF_RASTER: begin
                    readable = 1'b1;
                end
                `GCR_OFF_PSHIFT: begin
                    readable = 1'b1;
                end
                `GCR_OFF_ADDR: begin
                    readable = 1'b1;
                end
                `GCR_OFF_STEP1: begin
                    readable = 1'b1;
                end
                `GCR_OFF_STEP2: begin
                    readable = 1'b1;
                end
                `GCR_OFF_STEP3: begin
                    readable = 1'b1;
                end
                `GCR_OFF_CONT: begin
                    readable = 1'b1;
                end
                `GCR_OFF_DEPTH: begin
                    readable = 1'b1;
                end
                `GCR_OFF_STENCIL: begin
                    readable = 1'b1;
                end
                `GCR_OFF_CUR_BASE: begin
                    readable = 1'b1; // RULE12
                end
                `GCR_OFF_HORZ: begin
                    readable = 1'b1;
                end
                `GCR_OFF_VERT: begin
                    readable = 1'b1;
                end
                `GCR_OFF_VALID: begin
                    readable = 1'b1;
                end
                `GCR_OFF_CUR_POS: begin
                    readable = 1'b1;
                end
                `GCR_OFF_VSHIFT: begin
                    readable = 1'b1; // RULE11
                end
                `GCR_OFF_INT_STATE: begin
                    readable = 1'b1;
                end
                `GCR_OFF_DATA: begin
                    readable = 1'b1;
                end
                `GCR_OFF_RED_STEP: begin
                    readable = 1'b1;
                end
                `GCR_OFF_GRN_STEP: begin
                    readable = 1'b1;
                end
                `GCR_OFF_BLU_STEP: begin
                    readable = 1'b1;
                end
                `GCR_OFF_ZSTEP_LO: begin
                    readable = 1'b1;
                end
                `GCR_OFF_ZSTEP_HI: begin
                    readable = 1'b1;
                end
                `GCR_OFF_XFER_BASE: begin
                    readable = 1'b1; // RULE10
                end
                `GCR_OFF_LINE_WID: begin
                    readable = 1'b1;
                end
                `GCR_OFF_ZVAL_LO: begin
                    readable = 1'b1;
                end
                `GCR_OFF_ZVAL_HI: begin
                    readable = 1'b1;
                end
                `GCR_OFF_ZBASE: begin
                    readable = 1'b1;
                end
                `GCR_OFF_RED_VAL: begin
                    readable = 1'b1;
                end
                `GCR_OFF_GRN_VAL: begin
                    readable = 1'b1;
                end
                `GCR_OFF_BLUE_VAL: begin
                    readable = 1'b1;
                end
                `GCR_OFF_PAL_DATA: begin
                    readable = 1'b1; // RULE9
                end
                `GCR_OFF_CMD_STATE: begin
                    readable = 1'b1;
                end
                default: begin
                    readable = 1'b0; // RULE15
                end
            endcase
        end
    endfunction

    // Write-only locations
    function write_only;
        input [8:0] off;
        begin
            case (off)
                `GCR_OFF_PLANE: begin
                    write_only = 1'b1;
                end
                `GCR_OFF_PXM_PERS: begin
                    write_only = 1'b1; // RULE6
                end
                `GCR_OFF_VID_BASE: begin
                    write_only = 1'b1;
                end
                `GCR_OFF_ADDR_ALI: begin
                    write_only = 1'b1; // RULE16
                end
                `GCR_OFF_SPAN: begin
                    write_only = 1'b1;
                end
                `GCR_OFF_PAL_SETUP: begin
                    write_only = 1'b1; // RULE8
                end
                `GCR_OFF_NV_WRITE: begin
                    write_only = 1'b1;
                end
                `GCR_OFF_CLK_GEN: begin
                    write_only = 1'b1;
                end
                `GCR_OFF_FILL0: begin
                    write_only = 1'b1; // RULE4
                end
                `GCR_OFF_FILL1: begin
                    write_only = 1'b1; // RULE4
                end
                `GCR_OFF_FILL2: begin
                    write_only = 1'b1; // RULE4
                end
                `GCR_OFF_FILL3: begin
                    write_only = 1'b1; // RULE4
                end
                `GCR_OFF_FILL4: begin
                    write_only = 1'b1; // RULE4
                end
                `GCR_OFF_FILL5: begin
                    write_only = 1'b1; // RULE4
                end
                `GCR_OFF_FILL6: begin
                    write_only = 1'b1; // RULE4
                end
                `GCR_OFF_FILL7: begin
                    write_only = 1'b1; // RULE4
                end
                `GCR_OFF_COPY_SRC: begin
                    write_only = 1'b1; // RULE2
                end
                `GCR_OFF_COPY_DST: begin
                    write_only = 1'b1; // RULE3
                end
                `GCR_OFF_SRC_ALI1: begin
                    write_only = 1'b1; // RULE2
                end
                `GCR_OFF_DST_ALI1: begin
                    write_only = 1'b1; // RULE3
                end
                `GCR_OFF_SRC_ALI2: begin
                    write_only = 1'b1; // RULE2
                end
                `GCR_OFF_DST_ALI2: begin
                    write_only = 1'b1; // RULE3
                end
                `GCR_OFF_SRC_ALI3: begin
                    write_only = 1'b1; // RULE2
                end
                `GCR_OFF_COPY_LAST: begin
                    write_only = 1'b1; // RULE3
                end
                default: begin
                    // Sixteen slope slots form one run below the fill colours
                    write_only = (off >= `GCR_OFF_SLOPE_N0) && (off < `GCR_OFF_FILL0);
                end
            endcase
        end
    endfunction

    // Storage slot after folding aliases onto their primaries
    function [6:0] store_index;
        input [8:0] off;
        begin
            if (off == `GCR_OFF_ADDR_ALI) begin
                store_index = OFF_ADDR[8:2]; // RULE16
            end else if (off > `GCR_OFF_COPY_DST && off <= `GCR_OFF_COPY_LAST) begin
                // Even dwords fold to the source, odd ones to the destination
                if (off[2] == 1'b0) begin
                    store_index = OFF_COPY_SRC[8:2]; // RULE2
                end else begin
                    store_index = OFF_COPY_DST[8:2]; // RULE3
                end
            end else begin
                store_index = off[8:2];
            end
        end
    endfunction

    // Decoded view of the current request
    wire       is_rd;
    wire       is_wo;
    wire       is_wr;
    wire [6:0] slot;

    assign is_rd = readable(core_off);
    assign is_wo = write_only(core_off);
    assign is_wr = is_rd | is_wo;
    assign slot  = store_index(core_off);

    // One word per dword slot; reserved slots are never written
    reg [31:0] regs_q [0:127];

    // Write path
    wire do_write;
    assign do_write = req_i && wr_i && space_hit && is_wr; // RULE15

    integer i;
    always @(posedge clock_i) begin
        if (rst_i) begin
            for (i = 0; i < 128; i = i + 1) begin
                regs_q[i] <= `GCR_RESET_VAL;
            end
        end else if (do_write) begin
            regs_q[slot] <= wdata_i; // RULE2 RULE3 RULE16
        end
    end

    // Read value, before registering
    reg [31:0] rdata_d;

    always @* begin
        rdata_d = 32'h0000_0000;
        if (is_rd) begin
            rdata_d = regs_q[slot];
            // Live engine state replaces the stored busy bit
            if (core_off == `GCR_OFF_CMD_STATE) begin
                rdata_d[`GCR_BUSY_BIT] = busy_i; // RULE7
            end
        end
    end

    // Answer and write notification, one cycle after the request
    always @(posedge clock_i) begin
        if (rst_i) begin
            ack_o      <= 1'b0;
            rdata_o    <= 32'h0000_0000;
            wr_pulse_o <= 1'b0;
            wr_index_o <= 7'h00;
            wr_data_o  <= 32'h0000_0000;
        end else begin
            ack_o      <= req_i && space_hit;
            wr_pulse_o <= do_write;
            if (req_i && space_hit && !wr_i) begin
                rdata_o <= rdata_d; // RULE15
            end
            if (do_write) begin
                // Downstream sees the canonical slot, so aliases look identical
                wr_index_o <= slot; // RULE16
                wr_data_o  <= wdata_i;
            end
        end
    end

    // Stored settings that steer the drawing engine
    assign drawing_mode_o = regs_q[OFF_MODE[8:2]];
    assign draw_address_o = regs_q[OFF_ADDR[8:2]];

endmodule // gcr_register_map

// ---- verification/gcr_map_checker.sv ----
// Port assertions for the register window.
// Bound into gcr_register_map; offsets follow the map header.
`include "gcr_regs.vh"
module gcr_map_checker (
    input wire logic        clock_i, rst_i, req_i, wr_i, busy_i, ack_o, wr_pulse_o,
    input wire logic [31:0] addr_i, wdata_i, pci_base_i, rdata_o, wr_data_o,
    input wire logic [31:0] drawing_mode_o, draw_address_o,
    input wire logic [3:0]  be_i,
    input wire logic [6:0]  wr_index_o
);
    timeunit 1ns / 1ns;
    wire [31:0] rel_w = addr_i - pci_base_i - `GCR_CORE_OFF - `GCR_REG_OFF;
    wire        hit_w = req_i && rel_w[31:20] == 12'h000;
    wire [6:0]  off_w = rel_w[8:2];
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence wr_to(c); hit_w && wr_i && c; endsequence
    sequence rd_to(c); hit_w && !wr_i && c; endsequence
    AST_ACK: assert property (ack_o == $past(hit_w))
        else $error("ack");
    AST_SRC: assert property (wr_to(off_w inside {7'h5a, 7'h5c, 7'h5e}) |=> wr_pulse_o && wr_index_o == 7'h58)
        else $error("src alias");
    AST_DST: assert property (wr_to(off_w inside {7'h5b, 7'h5d, 7'h5f}) |=> wr_pulse_o && wr_index_o == 7'h59)
        else $error("dst alias");
    AST_ADR: assert property (wr_to(off_w inside {7'h0f, 7'h2b}) |=> draw_address_o == $past(wdata_i))
        else $error("addr alias");
    AST_RSV: assert property (wr_to(off_w == 7'h15) |=> ack_o && !wr_pulse_o)
        else $error("rsv write");
    AST_CBUF: assert property (wr_to(off_w < 7'h08) |=> wr_data_o == $past(wdata_i) && wr_index_o == $past(off_w))
        else $error("copy buf");
    AST_WO: assert property (rd_to(off_w inside {7'h0a, 7'h17, 7'h30, 7'h50}) |=> rdata_o == 32'h0)
        else $error("wo read");
    AST_BUSY: assert property (rd_to(off_w == 7'h7e) |=> rdata_o[0] == $past(busy_i))
        else $error("busy bit");
endmodule // gcr_map_checker
bind gcr_register_map gcr_map_checker gcr_map_checker_inst (.clock_i(clock_i), .rst_i(rst_i), .req_i(req_i),
    .wr_i(wr_i), .busy_i(busy_i), .ack_o(ack_o), .wr_pulse_o(wr_pulse_o), .addr_i(addr_i), .wdata_i(wdata_i),
    .pci_base_i(pci_base_i), .rdata_o(rdata_o), .wr_data_o(wr_data_o), .drawing_mode_o(drawing_mode_o),
    .draw_address_o(draw_address_o), .be_i(be_i), .wr_index_o(wr_index_o));

// ---- verification/gcr_host.sv ----
// Host model: one dword access at a time.
// Released address and data lines carry inverted junk; wr_o and be_o keep their stale values.
module gcr_host (
    input  wire logic        clock_i, ack_i,
    input  wire logic [31:0] rdata_i,
    output logic             req_o = 1'b0, wr_o = 1'b0,
    output logic      [31:0] addr_o = 32'h0, wdata_o = 32'h0,
    output logic      [3:0]  be_o = 4'h0
);
    timeunit 1ns / 1ns;
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic ok, output logic [31:0] rd);
        @(negedge clock_i);
        req_o = 1'b1;
        wr_o = w;
        addr_o = a;
        wdata_o = d;
        be_o = a[5:2];
        @(negedge clock_i);
        // Answer stands for this one cycle only
        ok = ack_i;
        rd = rdata_i;
        req_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule // gcr_host

// ---- verification/gcr_register_map_bench.sv ----
// Directed bench for the register window.
// Host model makes accesses; bench owns reset, base and busy.
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected %0t got %h want %h", $time, (a), (e)); end end
module gcr_register_map_bench;
    timeunit 1ns / 1ns;
    logic        clock_i = 0, rst_i = 1, busy = 0, ok, req, wr, ack, wp;
    logic [31:0] base = 32'h0800_0000, addr, wd, rdata, rv, dmode;
    logic [3:0]  be;
    logic [6:0]  idx;
    logic [8:0]  rw_t[5] = '{9'h060, 9'h078, 9'h098, 9'h1f0, 9'h02c};
    logic [8:0]  wo_t[7] = '{9'h05c, 9'h0c0, 9'h140, 9'h15c, 9'h160, 9'h164, 9'h028};
    logic [8:0]  al_t[7] = '{9'h168, 9'h170, 9'h178, 9'h16c, 9'h174, 9'h17c, 9'h0ac};
    logic [6:0]  ai_t[7] = '{7'h58, 7'h58, 7'h58, 7'h59, 7'h59, 7'h59, 7'h0f};
    int          num_errors = 0, checks = 0;
    always #20 clock_i = ~clock_i;
    gcr_register_map gcr_register_map_inst (.clock_i(clock_i), .rst_i(rst_i), .req_i(req), .wr_i(wr),
        .addr_i(addr), .wdata_i(wd), .be_i(be), .pci_base_i(base), .busy_i(busy), .ack_o(ack), .rdata_o(rdata),
        .wr_pulse_o(wp), .wr_index_o(idx), .wr_data_o(), .drawing_mode_o(dmode), .draw_address_o());
    gcr_host gcr_host_inst (.clock_i(clock_i), .ack_i(ack), .rdata_i(rdata), .req_o(req), .wr_o(wr),
        .addr_o(addr), .wdata_o(wd), .be_o(be));
    function automatic logic [31:0] at(input int r, input logic [8:0] o);
        return base + 32'h0010_0000 + r * 512 + o;
    endfunction
    task automatic put(input logic [31:0] a, d);
        gcr_host_inst.xfer(1'b1, a, d, ok, rv);
        `CHK(ok, 1'b1)
    endtask
    task automatic get(input logic [31:0] a, e);
        gcr_host_inst.xfer(1'b0, a, 32'h0, ok, rv);
        `CHK(rv, e)
    endtask
    task print_verdict;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #40000;
        num_errors++;
        print_verdict;
    end
    initial begin
        repeat (10) @(negedge clock_i);
        rst_i = 0;
        for (int i = 0; i < 8; i++) put(at(i, 9'(i * 4)), 32'hc0de_0000 + i);
        for (int i = 0; i < 8; i++) get(at(2047, 9'(i * 4)), 32'hc0de_0000 + i);
        foreach (rw_t[i]) put(at(3, rw_t[i]), {23'h0, rw_t[i]});
        foreach (rw_t[i]) get(at(0, rw_t[i]), {23'h0, rw_t[i]});
        put(at(5, 9'h030), 32'h0000_0d0e);
        `CHK(dmode, 32'h0000_0d0e)
        $display("test read write done");
        foreach (wo_t[i]) begin
            put(at(1, wo_t[i]), 32'hffff_ffff);
            `CHK(wp, 1'b1)
            `CHK(idx, wo_t[i][8:2])
            get(at(1, wo_t[i]), 32'h0);
        end
        foreach (al_t[i]) begin
            put(at(4, al_t[i]), 32'h0a11_0000 + i);
            `CHK(idx, ai_t[i])
        end
        get(at(0, 9'h03c), 32'h0a11_0006);
        $display("test write only and alias done");
        put(at(0, 9'h054), 32'h1234_5678);
        `CHK(wp, 1'b0)
        gcr_host_inst.xfer(1'b0, base + 32'h54, 32'h0, ok, rv);
        `CHK(ok, 1'b0)
        rst_i = 1;
        repeat (2) @(negedge clock_i);
        rst_i = 0;
        get(at(0, 9'h060), 32'h0);
        `CHK(dmode, 32'h0)
        busy = 1;
        put(at(0, 9'h1f8), 32'hf0f0_00f0);
        get(at(0, 9'h1f8), 32'hf0f0_00f1);
        busy = 0;
        get(at(0, 9'h1f8), 32'hf0f0_00f0);
        $display("test refusal and status done");
        print_verdict;
    end
endmodule // gcr_register_map_bench
